// *** verilog/lfs_link_fault.sv ***
// Link fault signaling for a four-lane 10 Gb/s reconciliation sublayer.
//
// Operation
// - Sequence with 00, 00, 02 in lanes 1 to 3 is remote fault.
// - Lane 3 values 00 or 03 and above are reserved, never faults.
// - Fault column is a Sequence set with local or remote type in lanes 1-3.
// - Fault-free column counter advances on each receive clock edge unless cleared.
// - Count consecutive fault sets of the same type against the stored type.
// - Keep the type of the most recent fault set for comparison.
// - State takes fault type after four same-type faults without 128-column gap.
// - State returns to OK after 128 columns free of fault sets.
// - In OK state send MAC frames, and Idle between frames.
// - In local fault state send remote fault Sequence sets continuously.
// - In remote fault state send only Idle, suppressing MAC frames.
// - Report fault state to MAC as link health; OK again when faults stop.
// - Reset holds and initialises all fault logic.
// - Sequence is 9C with control bit set, valid only in lane 0.
// - Idle is 07 with control bit set and fills the gap.
// - Receive control and data are sampled on both receive clock edges.
// - Lane n occupies data bits 8n+7 down to 8n.
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

module lfs_link_fault (
    input wire logic sys_clk,                      // System clock, 25 MHz.
    input wire logic rst_b,                        // Synchronous reset, active low.
    input wire logic rx_clk,                       // Receive clock from the PHY.
    input wire lfs_pkg::lfs_col_t rx_col,          // Receive control and data lanes.
    input wire lfs_pkg::lfs_col_t mac_tx_col,      // Column offered by the MAC.
    input wire logic mac_tx_valid,                 // MAC column is valid.
    output logic mac_tx_ready,                     // Transmit path accepts MAC columns.
    output lfs_pkg::lfs_col_t xgmii_tx,            // Transmit control and data lanes.
    output logic link_health_primitive,            // High while the fault state is OK.
    output lfs_pkg::lfs_state_t link_fault,        // Current fault state.
    input wire logic wb_cyc_i,                     // Wishbone cycle.
    input wire logic wb_stb_i,                     // Wishbone strobe.
    input wire logic wb_we_i,                      // Wishbone write enable.
    input wire logic [7:0] wb_adr_i,               // Wishbone byte address.
    input wire logic [3:0] wb_sel_i,               // Wishbone byte selects.
    input wire logic [31:0] wb_dat_i,              // Wishbone write data.
    output logic [31:0] wb_dat_o,                  // Wishbone read data.
    output logic wb_ack_o                          // Wishbone acknowledge.
);
    import lfs_pkg::*;

    // ==========================================================
    // Receive clock and lane synchronisers.
    logic rxclk_s1_reg;
    logic rxclk_s2_reg;
    logic rxclk_s3_reg;
    lfs_col_t rxcol_s1_reg;
    lfs_col_t rxcol_s2_reg;

    always_ff @(posedge sys_clk) begin
        rxclk_s1_reg <= rx_clk;
        rxclk_s2_reg <= rxclk_s1_reg;
        rxclk_s3_reg <= rxclk_s2_reg;
        rxcol_s1_reg <= rx_col;
        rxcol_s2_reg <= rxcol_s1_reg;
    end

    // Either edge of the receive clock presents a new column.
    wire col_evt = rxclk_s2_reg ^ rxclk_s3_reg;

    // ==========================================================
    // Column classification.
    wire [7:0] lane0 = rxcol_s2_reg.dat[LFS_LANE0_LSB +: 8];
    wire [7:0] lane1 = rxcol_s2_reg.dat[LFS_LANE1_LSB +: 8];
    wire [7:0] lane2 = rxcol_s2_reg.dat[LFS_LANE2_LSB +: 8];
    wire [7:0] lane3 = rxcol_s2_reg.dat[LFS_LANE3_LSB +: 8];
    wire seq_col = (rxcol_s2_reg.ctl == LFS_CTL_SEQ) && (lane0 == LFS_SEQ_CHAR);
    wire zero_12 = (lane1 == LFS_ZERO_BYTE) && (lane2 == LFS_ZERO_BYTE);
    wire type_local = (lane3 == LFS_TYPE_LOCAL);
    wire type_remote = (lane3 == LFS_TYPE_REMOTE);
    // Reserved lane 3 values fall out here and count as fault-free columns.
    wire fault_col = seq_col && zero_12 && (type_local || type_remote);
    wire seq_is_remote = type_remote;

    // ==========================================================
    // Fault state machine.
    logic [6:0] col_cnt_reg;
    logic [2:0] seq_cnt_reg;
    logic last_remote_reg;
    lfs_state_t link_fault_reg;
    logic [15:0] fcount_reg;
    logic [31:0] ctrl_reg;

    wire same_type = (seq_cnt_reg != 3'h0) && (seq_is_remote == last_remote_reg);
    wire [2:0] seq_cnt_inc = (seq_cnt_reg == LFS_SEQ_NEEDED) ? seq_cnt_reg : seq_cnt_reg + 3'h1;
    wire [2:0] seq_cnt_hit = same_type ? seq_cnt_inc : 3'h1;
    wire gap_done = (col_cnt_reg == LFS_COL_LAST);
    wire lfs_state_t rx_type = seq_is_remote ? LFS_REMOTE : LFS_LOCAL;

    logic [6:0] col_cnt_next;
    logic [2:0] seq_cnt_next;
    logic last_remote_next;
    lfs_state_t link_fault_next;

    always_comb begin
        col_cnt_next = col_cnt_reg;
        seq_cnt_next = seq_cnt_reg;
        last_remote_next = last_remote_reg;
        link_fault_next = link_fault_reg;
        if (col_evt && fault_col) begin
            col_cnt_next = 7'h00;
            seq_cnt_next = seq_cnt_hit;
            last_remote_next = seq_is_remote;
            if (seq_cnt_hit == LFS_SEQ_NEEDED) begin
                link_fault_next = rx_type;
            end
        end else if (col_evt) begin
            col_cnt_next = col_cnt_reg + 7'h01;
            if (gap_done) begin
                // A full gap breaks any run and clears the fault.
                seq_cnt_next = 3'h0;
                link_fault_next = LFS_OK;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            col_cnt_reg <= 7'h00;
            seq_cnt_reg <= 3'h0;
            last_remote_reg <= 1'b0;
            link_fault_reg <= LFS_OK;
        end else begin
            col_cnt_reg <= col_cnt_next;
            seq_cnt_reg <= seq_cnt_next;
            last_remote_reg <= last_remote_next;
            link_fault_reg <= link_fault_next;
        end
    end

    assign link_fault = link_fault_reg;
    assign link_health_primitive = (link_fault_reg == LFS_OK);

    // ==========================================================
    // Transmit column selection.
    wire react_en = ctrl_reg[LFS_CTRL_REACT_BIT];
    wire pass_mac = !react_en || (link_fault_reg == LFS_OK);
    wire lfs_col_t idle_col = '{ctl: LFS_CTL_IDLE, dat: {4{LFS_IDLE_CHAR}}};
    wire lfs_col_t rf_col = '{ctl: LFS_CTL_SEQ,
                              dat: {LFS_TYPE_REMOTE, LFS_ZERO_BYTE, LFS_ZERO_BYTE, LFS_SEQ_CHAR}};
    wire lfs_col_t tx_next = pass_mac ? (mac_tx_valid ? mac_tx_col : idle_col)
                           : (link_fault_reg == LFS_LOCAL) ? rf_col
                           : idle_col;
    lfs_col_t tx_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            tx_reg <= '{ctl: LFS_CTL_IDLE, dat: {4{LFS_IDLE_CHAR}}};
        end else begin
            tx_reg <= tx_next;
        end
    end

    assign xgmii_tx = tx_reg;
    assign mac_tx_ready = pass_mac;

    // ==========================================================
    // Wishbone slave.
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_ctrl = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == LFS_CTRL_OFS);
    wire wr_fcnt = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == LFS_FCOUNT_OFS);
    wire [31:0] status_word = {26'h000_0000, seq_cnt_reg, link_health_primitive, link_fault_reg};
    wire [31:0] rd_word = (wb_adr_i == LFS_CTRL_OFS) ? ctrl_reg
                        : (wb_adr_i == LFS_STATUS_OFS) ? status_word
                        : (wb_adr_i == LFS_FCOUNT_OFS) ? {16'h0000, fcount_reg}
                        : 32'h0000_0000;
    wire fault_hit = col_evt && fault_col;
    logic ack_reg;
    logic [31:0] rdat_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            ctrl_reg <= LFS_CTRL_RESET;
        end else begin
            ack_reg <= wb_req;
            rdat_reg <= wb_req ? rd_word : 32'h0000_0000;
            if (wr_ctrl) begin
                ctrl_reg <= {31'h0000_0000, wb_dat_i[LFS_CTRL_REACT_BIT]};
            end
        end
    end

    // Fault column tally; a new fault in the clearing cycle still counts.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fcount_reg <= LFS_FCOUNT_RESET;
        end else if (fault_hit) begin
            fcount_reg <= (wr_fcnt ? 16'h0000 : fcount_reg) + 16'h0001;
        end else if (wr_fcnt) begin
            fcount_reg <= LFS_FCOUNT_RESET;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // ==========================================================
    // Assertions.
    edge_sample_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        col_evt |-> $past(rxclk_s2_reg) != rxclk_s2_reg)
        else $error("Column taken without a receive clock edge.");

    col_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (col_evt && fault_col) |=> col_cnt_reg == 7'h00)
        else $error("Fault column did not clear the column counter.");

    col_count_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (col_evt && !fault_col) |=> col_cnt_reg == $past(col_cnt_reg) + 7'h01)
        else $error("Fault-free column not counted.");

    reserved_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (col_evt && seq_col && !type_local && !type_remote && !gap_done)
        |=> $stable(seq_cnt_reg) && $stable(link_fault_reg))
        else $error("Reserved sequence set changed the fault logic.");

    last_type_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (col_evt && fault_col) |=> last_remote_reg == $past(type_remote))
        else $error("Stored fault type not updated.");

    fourth_fault_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (col_evt && fault_col && same_type && seq_cnt_reg == 3'h3)
        |=> link_fault_reg == $past(rx_type))
        else $error("Fourth same-type fault did not set the state.");

    gap_ok_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (col_evt && !fault_col && gap_done) |=> link_fault_reg == LFS_OK && seq_cnt_reg == 3'h0)
        else $error("State not OK after a fault-free gap.");

    state_on_col_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $changed(link_fault_reg) |-> $past(col_evt) && link_health_primitive == (link_fault_reg == LFS_OK))
        else $error("Fault state moved without a column.");

    mac_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (link_fault_reg == LFS_OK && mac_tx_valid) |=> xgmii_tx == $past(mac_tx_col))
        else $error("MAC column not sent in OK state.");

    local_rf_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (link_fault_reg == LFS_LOCAL && react_en) |=> xgmii_tx.ctl == 4'h1 && xgmii_tx.dat == 32'h0200_009C)
        else $error("Local fault state not sending remote fault.");

    remote_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (link_fault_reg == LFS_REMOTE && react_en) |=> xgmii_tx.ctl == 4'hF && xgmii_tx.dat == 32'h0707_0707)
        else $error("Remote fault state not sending idle.");

    reset_init_a: assert property (@(posedge sys_clk)
        !rst_b |=> link_fault_reg == LFS_OK && seq_cnt_reg == 3'h0 && col_cnt_reg == 7'h00)
        else $error("Reset did not initialise the fault logic.");

    ack_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o)
        else $error("Bus acknowledge held longer than one cycle.");

    ack_resp_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("Bus request not acknowledged in the next cycle.");

    rdat_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("Read data not zero outside an acknowledge.");

    ctrl_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_ctrl |=> ctrl_reg[0] == $past(wb_dat_i[LFS_CTRL_REACT_BIT]) && ctrl_reg[31:1] == 31'h0000_0000)
        else $error("Control write not applied.");

    fcnt_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_fcnt && !fault_hit) |=> fcount_reg == 16'h0000)
        else $error("Fault tally not cleared by a write.");

    fcnt_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (fault_hit && !wr_fcnt) |=> fcount_reg == $past(fcount_reg) + 16'h0001)
        else $error("Fault column not tallied.");

    fcnt_race_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (fault_hit && wr_fcnt) |=> fcount_reg == 16'h0001)
        else $error("Fault column lost while the tally was cleared.");

    fcnt_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!fault_hit && !wr_fcnt) |=> $stable(fcount_reg))
        else $error("Fault tally moved without a cause.");

    ok_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (pass_mac && !mac_tx_valid) |=> xgmii_tx.ctl == LFS_CTL_IDLE && xgmii_tx.dat == {4{LFS_IDLE_CHAR}})
        else $error("Idle not sent between MAC columns.");

    remote_block_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (link_fault_reg == LFS_REMOTE && react_en) |-> !mac_tx_ready)
        else $error("MAC columns accepted in remote fault state.");

    local_block_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (link_fault_reg == LFS_LOCAL && react_en) |-> !mac_tx_ready)
        else $error("MAC columns accepted in local fault state.");

    seq_sat_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        seq_cnt_reg <= LFS_SEQ_NEEDED)
        else $error("Fault run tally beyond its limit.");

    nonfault_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (col_evt && !fault_col && !gap_done)
        |=> $stable(seq_cnt_reg) && $stable(link_fault_reg) && $stable(last_remote_reg))
        else $error("Fault-free column disturbed the fault run.");

    no_evt_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !col_evt |=> $stable(col_cnt_reg) && $stable(seq_cnt_reg) && $stable(link_fault_reg))
        else $error("Fault logic moved without a column.");

    type_change_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (col_evt && fault_col && !same_type) |=> seq_cnt_reg == 3'h1)
        else $error("New fault type did not restart the run.");

    wrong_ctl_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (col_evt && rxcol_s2_reg.ctl != LFS_CTL_SEQ) |-> !fault_col)
        else $error("Column with a wrong control pattern taken as a fault.");

    set_four_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ($changed(link_fault_reg) && link_fault_reg != LFS_OK) |-> seq_cnt_reg == LFS_SEQ_NEEDED)
        else $error("Fault state set before four same-type faults.");

    ok_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ($changed(link_fault_reg) && link_fault_reg == LFS_OK) |-> $past(gap_done))
        else $error("Fault state cleared without a full gap.");

    evt_spacing_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        col_evt |=> !col_evt)
        else $error("Column events on adjacent cycles.");

    rdat_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wb_req && !wb_we_i && wb_adr_i == LFS_STATUS_OFS) |=> wb_dat_o[2] == $past(link_health_primitive))
        else $error("Status read does not show link health.");

    tx_reset_a: assert property (@(posedge sys_clk)
        !rst_b |=> xgmii_tx.ctl == LFS_CTL_IDLE && xgmii_tx.dat == {4{LFS_IDLE_CHAR}})
        else $error("Transmit lanes not idle after reset.");

endmodule

`default_nettype wire

// *** pkg/lfs_pkg.sv ***
// Shared constants and types for the link fault signaling block.
package lfs_pkg;

    // ==========================================================
    // Column carrier on the four-lane interface.
    typedef struct packed {
        logic [3:0] ctl;
        logic [31:0] dat;
    } lfs_col_t;

    // ==========================================================
    // Fault state, Gray coded along OK -> Local -> Remote.
    typedef enum logic [1:0] {
        LFS_OK = 2'b00,
        LFS_LOCAL = 2'b01,
        LFS_REMOTE = 2'b11
    } lfs_state_t;

    // ==========================================================
    // Character codes and sequence types.
    localparam logic [7:0] LFS_SEQ_CHAR = 8'h9C;
    localparam logic [7:0] LFS_IDLE_CHAR = 8'h07;
    localparam logic [7:0] LFS_ZERO_BYTE = 8'h00;
    localparam logic [7:0] LFS_TYPE_LOCAL = 8'h01;
    localparam logic [7:0] LFS_TYPE_REMOTE = 8'h02;
    localparam logic [3:0] LFS_CTL_SEQ = 4'h1;
    localparam logic [3:0] LFS_CTL_IDLE = 4'hF;

    // ==========================================================
    // Lane field positions.
    localparam int LFS_LANE0_LSB = 0;
    localparam int LFS_LANE1_LSB = 8;
    localparam int LFS_LANE2_LSB = 16;
    localparam int LFS_LANE3_LSB = 24;

    // ==========================================================
    // Column counts.
    localparam logic [6:0] LFS_COL_LAST = 7'h7F;
    localparam logic [2:0] LFS_SEQ_NEEDED = 3'h4;

    // ==========================================================
    // Register map and reset values.
    localparam logic [7:0] LFS_CTRL_OFS = 8'h00;
    localparam logic [7:0] LFS_STATUS_OFS = 8'h04;
    localparam logic [7:0] LFS_FCOUNT_OFS = 8'h08;
    localparam int LFS_CTRL_REACT_BIT = 0;
    localparam logic [31:0] LFS_CTRL_RESET = 32'h0000_0001;
    localparam logic [15:0] LFS_FCOUNT_RESET = 16'h0000;

endpackage

// *** verif/lfs_phy_model.sv ***
// Behavioural receive side of the PHY coding sublayer for the link fault bench.
`timescale 1ns/10ps
`default_nettype none

module lfs_phy_model (
    input wire logic seq_en,           // Present a Sequence column instead of Idle.
    input wire logic [3:0] seq_ctl,    // Control pattern of the Sequence column.
    input wire logic [7:0] seq_type,   // Lane 3 type value of the Sequence column.
    output logic rx_clk,               // Free-running receive clock.
    output lfs_pkg::lfs_col_t rx_col   // Receive lanes.
);
    import lfs_pkg::*;

    // ==========================================================
    // The clock runs free and a new column follows every edge.
    initial begin
        rx_clk = 1'b0;
        rx_col = '{ctl: LFS_CTL_IDLE, dat: {4{LFS_IDLE_CHAR}}};
        #10;
        forever begin
            #160;
            rx_clk = ~rx_clk;
            if (seq_en) begin
                rx_col = '{ctl: seq_ctl, dat: {seq_type, LFS_ZERO_BYTE, LFS_ZERO_BYTE, LFS_SEQ_CHAR}};
            end else begin
                rx_col = '{ctl: LFS_CTL_IDLE, dat: {4{LFS_IDLE_CHAR}}};
            end
        end
    end
endmodule

`default_nettype wire

// *** verif/lfs_link_fault_tb.sv ***
// Self-checking bench for the link fault signaling block.
`timescale 1ns/10ps
`default_nettype none

module lfs_link_fault_tb;
    import lfs_pkg::*;

    logic sys_clk, rst_b, rx_clk, mac_tx_valid, mac_tx_ready, link_health_primitive;
    logic seq_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0] seq_ctl, wb_sel_i;
    logic [7:0] seq_type, wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    lfs_col_t rx_col, mac_tx_col, xgmii_tx;
    lfs_state_t link_fault;
    int n_errors = 0;
    int comparisons = 0;
    localparam logic [35:0] IDLE_COL = {LFS_CTL_IDLE, {4{LFS_IDLE_CHAR}}};
    localparam logic [35:0] MAC_COL = {4'h0, 32'h1234_5678};
    localparam logic [35:0] RF_COL = {LFS_CTL_SEQ, LFS_TYPE_REMOTE, LFS_ZERO_BYTE, LFS_ZERO_BYTE, LFS_SEQ_CHAR};

    lfs_phy_model i_phy (.seq_en(seq_en), .seq_ctl(seq_ctl), .seq_type(seq_type), .rx_clk(rx_clk), .rx_col(rx_col));

    lfs_link_fault i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .rx_clk(rx_clk), .rx_col(rx_col),
        .mac_tx_col(mac_tx_col), .mac_tx_valid(mac_tx_valid), .mac_tx_ready(mac_tx_ready),
        .xgmii_tx(xgmii_tx), .link_health_primitive(link_health_primitive), .link_fault(link_fault),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    // ==========================================================
    // Tasks.
    task automatic end_sim;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle; read data is taken at the ack edge.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wdat;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            n_errors++;
            $display("[ERR] %0t no bus acknowledge", $time);
            end_sim();
        end
    endtask

    // Present n Sequence columns, then Idle, then let the result settle.
    task automatic send(input logic [7:0] ty, input logic [3:0] ct, input int n);
        @(posedge sys_clk);
        seq_en <= 1'b1;
        seq_type <= ty;
        seq_ctl <= ct;
        repeat (n) @(rx_clk);
        @(posedge sys_clk);
        seq_en <= 1'b0;
        repeat (5) @(posedge sys_clk);
    endtask

    task automatic idle(input int n);
        repeat (n) @(rx_clk);
        repeat (5) @(posedge sys_clk);
    endtask

    // ==========================================================
    // Clock, watchdog and test sequence.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        #400_000;
        n_errors++;
        end_sim();
    end

    initial begin
        {rst_b, seq_en, mac_tx_valid, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
        {seq_ctl, seq_type, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hF;
        mac_tx_col = MAC_COL;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(36'(link_fault), 36'(LFS_OK));
        chk(xgmii_tx, IDLE_COL);
        wb(1'b0, LFS_CTRL_OFS, 32'h0000_0000);
        chk(36'(rd), 36'(LFS_CTRL_RESET));
        wb(1'b0, 8'h0C, 32'h0000_0000);
        chk(36'(rd), 36'h0_0000_0000);
        mac_tx_valid <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(xgmii_tx, MAC_COL);
        chk(36'(mac_tx_ready), 36'h0_0000_0001);
        send(8'h03, LFS_CTL_SEQ, 4);
        chk(36'(link_fault), 36'(LFS_OK));
        send(8'h00, LFS_CTL_SEQ, 4);
        chk(36'(link_fault), 36'(LFS_OK));
        send(LFS_TYPE_LOCAL, 4'h3, 4);
        chk(36'(link_fault), 36'(LFS_OK));
        send(LFS_TYPE_LOCAL, LFS_CTL_SEQ, 3);
        chk(36'(link_fault), 36'(LFS_OK));
        send(LFS_TYPE_LOCAL, LFS_CTL_SEQ, 1);
        chk(36'(link_fault), 36'(LFS_LOCAL));
        chk(36'(link_health_primitive), 36'h0_0000_0000);
        chk(xgmii_tx, RF_COL);
        wb(1'b0, LFS_STATUS_OFS, 32'h0000_0000);
        chk(36'(rd), 36'h0_0000_0021);
        chk(36'(mac_tx_ready), 36'h0_0000_0000);
        wb(1'b1, LFS_CTRL_OFS, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        chk(xgmii_tx, MAC_COL);
        wb(1'b1, LFS_CTRL_OFS, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk(xgmii_tx, RF_COL);
        send(LFS_TYPE_REMOTE, LFS_CTL_SEQ, 3);
        chk(36'(link_fault), 36'(LFS_LOCAL));
        send(LFS_TYPE_REMOTE, LFS_CTL_SEQ, 1);
        chk(36'(link_fault), 36'(LFS_REMOTE));
        chk(xgmii_tx, IDLE_COL);
        idle(124);
        chk(36'(link_fault), 36'(LFS_REMOTE));
        idle(3);
        chk(36'(link_fault), 36'(LFS_OK));
        chk(36'(link_health_primitive), 36'h0_0000_0001);
        chk(xgmii_tx, MAC_COL);
        send(LFS_TYPE_LOCAL, LFS_CTL_SEQ, 3);
        idle(128);
        send(LFS_TYPE_LOCAL, LFS_CTL_SEQ, 1);
        chk(36'(link_fault), 36'(LFS_OK));
        wb(1'b0, LFS_FCOUNT_OFS, 32'h0000_0000);
        chk(36'(rd), 36'h0_0000_000C);
        wb(1'b1, LFS_FCOUNT_OFS, 32'h0000_0000);
        wb(1'b0, LFS_FCOUNT_OFS, 32'h0000_0000);
        chk(36'(rd), 36'(LFS_FCOUNT_RESET));
        end_sim();
    end
endmodule

`default_nettype wire
